// ==== inc/agu_pkg.sv ====
// Constants, encodings and reset values shared by the address generation unit.
// Assumes a 16-bit address space and an 8-bit register file in four banks.
package agu_pkg;

  // Branch target selection
  typedef enum logic [2:0] {
    AGU_BR_NONE  = 3'b000,
    AGU_BR_REL   = 3'b001,
    AGU_BR_IMM16 = 3'b010,
    AGU_BR_FAST  = 3'b011,
    AGU_BR_TABLE = 3'b100,
    AGU_BR_PAIR  = 3'b101
  } agu_branch_e;

  // Operand address modes
  typedef enum logic [2:0] {
    AGU_OP_NONE   = 3'b000,
    AGU_OP_DIRECT = 3'b001,
    AGU_OP_SHORT  = 3'b010,
    AGU_OP_SPECL  = 3'b011,
    AGU_OP_BASED  = 3'b100
  } agu_opmode_e;

  // Implied accumulator operations
  typedef enum logic [2:0] {
    AGU_IMP_NONE = 3'b000,
    AGU_IMP_MUL  = 3'b001,
    AGU_IMP_DIV  = 3'b010,
    AGU_IMP_ADJ  = 3'b011,
    AGU_IMP_ROT  = 3'b100
  } agu_implied_e;

  // Table fetch sequencing
  typedef enum logic [1:0] {
    AGU_TB_IDLE = 2'b00,
    AGU_TB_LOW  = 2'b01,
    AGU_TB_HIGH = 2'b10
  } agu_table_e;

  localparam logic [15:0] AGU_PC_RESET      = 16'h0000;
  localparam logic [15:0] AGU_FAST_BASE     = 16'h0800;
  localparam logic [15:0] AGU_TABLE_BASE    = 16'h0040;
  localparam logic [15:0] AGU_TABLE_LAST    = 16'h007F;
  localparam int          AGU_TIDX_LSB      = 1;
  localparam int          AGU_TIDX_MSB      = 5;
  localparam int          AGU_SIGN_BIT      = 7;
  localparam logic [7:0]  AGU_SHORT_HIGH    = 8'hFE;
  localparam logic [7:0]  AGU_SHORT_SPLIT   = 8'h20;
  localparam int          AGU_SHORT_BIT8    = 8;
  localparam logic [7:0]  AGU_SPECL_HIGH    = 8'hFF;
  localparam logic [7:0]  AGU_SPECL_GAP_LO  = 8'hD0;
  localparam logic [7:0]  AGU_SPECL_GAP_HI  = 8'hDF;
  localparam logic [15:0] AGU_RAM_FIRST     = 16'hFE20;
  localparam logic [15:0] AGU_RAM_LAST      = 16'hFEFF;
  localparam logic [15:0] AGU_SFR_FIRST     = 16'hFF00;
  localparam logic [15:0] AGU_SFR_SHORTLAST = 16'hFF1F;

  // Register file index: bank in bits 4:3, register code in bits 2:0
  localparam logic [2:0]  AGU_REG_X = 3'h0;
  localparam logic [2:0]  AGU_REG_A = 3'h1;
  localparam logic [2:0]  AGU_REG_L = 3'h6;
  localparam logic [1:0]  AGU_PAIR_AX = 2'h0;
  localparam logic [1:0]  AGU_PAIR_HL = 2'h3;

  localparam logic [7:0]  AGU_MEMSIZE_RESET  = 8'hCF;
  localparam logic [7:0]  AGU_FLASH_USER     = 8'h08;
  localparam logic [7:0]  AGU_FLASH_ONBOARD  = 8'h0C;
  // Edges after release before the strap is trusted; the synchroniser needs four
  localparam int          AGU_STRAP_SETTLE   = 5;

endpackage

// ==== verilog/agu_sync.sv ====
// Three-stage synchroniser with agreement filter for a slow pin level.
// Assumes the pin changes far slower than mclk.
`timescale 1ns/1ps
`default_nettype none
module agu_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Pin and filtered level
  input  wire logic pin,
  output var  logic level
);

  logic [2:0] stage;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], pin};
    end
  end

  // Only the second and third stages are compared; the first feeds nothing else
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level <= stage[2];
    end
  end

endmodule
`default_nettype wire

// ==== verilog/agu_top.sv ====
// Address generation unit: program counter targets and operand addresses.
// Assumes the decoder presents one request per cycle and that table words
// are returned by memory one cycle after each table read strobe.
// How it works
// - non-branching step adds the instruction byte length to the program counter
// - relative displacement sign-extended from bit 7, added to next instruction start
// - short branch and every conditional branch use the relative target form
// - long call and long branch load the 16-bit immediate into the counter
// - fast call target is 0800H plus 11-bit field, staying in 0800H-0FFFH
// - table call reads the word entry picked by opcode bits 1-5 at 40H-7FH
// - register branch copies the accumulator pair into the program counter
// - multiply takes A and named register, product goes to accumulator pair
// - word divide reads and writes its dividend and quotient in accumulator pair
// - decimal adjust and digit rotates operate on the A register
// - register index is bank select flags joined with opcode register code
// - byte codes 0-7 are X,A,C,B,E,D,L,H; pair codes 0-3 are AX,BC,DE,HL
// - direct mode uses the 16-bit immediate unchanged as address
// - short direct maps 8-bit offset into FE20H-FF1FH, bit 8 set below 20H
// - short window splits into RAM FE20H-FEFFH and special registers from FF00H
// - special register mode puts FFH above the offset, excluding FFD0H-FFDFH
// - memory size register resets to CFH regardless of fitted memory
// - flash mode register resets to 08H, then shows 0CH in on-board mode from the fifth edge after release
// - based mode adds zero-extended offset to selected bank HL, carry dropped
`timescale 1ns/1ps
`default_nettype none
module agu_top
  import agu_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Mode strap
  input  wire logic        onboard_mode_pin,
  // Bank selection
  input  wire logic        bank_select_low,
  input  wire logic        bank_select_high,
  // Program counter request
  input  wire logic        step_valid,
  input  wire logic [1:0]  step_length,
  input  wire logic        branch_valid,
  input  wire agu_branch_e branch_kind,
  input  wire logic [7:0]  relative_displacement,
  input  wire logic [15:0] branch_immediate,
  input  wire logic [10:0] fast_call_target_field,
  input  wire logic [7:0]  table_opcode,
  // Table word return
  input  wire logic [7:0]  table_data,
  // Operand request
  input  wire logic        operand_valid,
  input  wire agu_opmode_e operand_mode,
  input  wire logic [15:0] operand_immediate,
  input  wire logic [2:0]  byte_register_code,
  input  wire logic [1:0]  pair_register_code,
  input  wire agu_implied_e implied_op,
  // Register values from the register file
  input  wire logic [15:0] accumulator_pair,
  input  wire logic [15:0] hl_pair,
  // Size register write
  input  wire logic        memsize_write,
  input  wire logic [7:0]  memsize_data,
  // Program counter outputs
  output var  logic [15:0] program_counter,
  output var  logic        branch_busy,
  output var  logic        table_read,
  output var  logic [15:0] table_addr,
  // Operand address outputs
  output var  logic        operand_addr_valid,
  output var  logic [15:0] operand_addr,
  output var  logic        operand_in_ram,
  output var  logic        operand_in_sfr,
  output var  logic        operand_unmapped,
  // Register selection outputs
  output var  logic [4:0]  byte_register_index,
  output var  logic [3:0]  pair_register_index,
  output var  logic        implied_valid,
  output var  logic [4:0]  implied_source_index,
  output var  logic [3:0]  implied_dest_pair,
  // Control registers
  output var  logic [7:0]  memory_size_register,
  output var  logic [7:0]  flash_mode_register
);

  logic        onboard_level;
  logic [2:0]  strap_count;
  agu_table_e  table_state;
  logic [7:0]  table_low;
  logic [1:0]  bank;
  logic [15:0] next_rel_target;
  logic [15:0] next_fast_target;
  logic [15:0] next_table_addr;
  logic [15:0] next_operand_addr;
  logic        next_in_ram;
  logic        next_in_sfr;
  logic        next_unmapped;

  agu_sync u_strap_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pin   (onboard_mode_pin),
    .level (onboard_level)
  );

  assign bank = {bank_select_high, bank_select_low};

  // The counter already points past the branch instruction when it is issued
  assign next_rel_target = program_counter +
                           {{8{relative_displacement[AGU_SIGN_BIT]}},
                            relative_displacement};
  assign next_fast_target = AGU_FAST_BASE | {5'h00, fast_call_target_field};
  assign next_table_addr  = AGU_TABLE_BASE |
                            {10'h000, table_opcode[AGU_TIDX_MSB:AGU_TIDX_LSB], 1'b0};

  // Operand address formation
  always_comb begin
    next_operand_addr = 16'h0000;
    unique case (operand_mode)
      AGU_OP_DIRECT: begin
        next_operand_addr = operand_immediate;
      end
      AGU_OP_SHORT: begin
        next_operand_addr = {AGU_SHORT_HIGH, operand_immediate[7:0]};
        next_operand_addr[AGU_SHORT_BIT8] = (operand_immediate[7:0] < AGU_SHORT_SPLIT);
      end
      AGU_OP_SPECL: begin
        next_operand_addr = {AGU_SPECL_HIGH, operand_immediate[7:0]};
      end
      AGU_OP_BASED: begin
        next_operand_addr = hl_pair + {8'h00, operand_immediate[7:0]};
      end
      default: begin
        next_operand_addr = 16'h0000;
      end
    endcase
  end

  // Region flags; the special register gap is flagged unmapped only in special register mode
  always_comb begin
    next_in_ram   = (next_operand_addr >= AGU_RAM_FIRST) &&
                    (next_operand_addr <= AGU_RAM_LAST);
    next_in_sfr   = (next_operand_addr >= AGU_SFR_FIRST);
    next_unmapped = 1'b0;
    if (operand_mode == AGU_OP_SPECL) begin
      next_unmapped = (operand_immediate[7:0] >= AGU_SPECL_GAP_LO) &&
                      (operand_immediate[7:0] <= AGU_SPECL_GAP_HI);
      next_in_sfr   = !next_unmapped;
    end
  end

  // Program counter update; a table call waits for two returned bytes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      program_counter <= AGU_PC_RESET;
    end else if (table_state == AGU_TB_HIGH) begin
      program_counter <= {table_data, table_low};
    end else if (branch_valid && table_state == AGU_TB_IDLE) begin
      unique case (branch_kind)
        AGU_BR_REL:   program_counter <= next_rel_target;
        AGU_BR_IMM16: program_counter <= branch_immediate;
        AGU_BR_FAST:  program_counter <= next_fast_target;
        AGU_BR_PAIR:  program_counter <= accumulator_pair;
        default:      program_counter <= program_counter;
      endcase
    end else if (step_valid && table_state == AGU_TB_IDLE) begin
      program_counter <= program_counter + {14'h0000, step_length};
    end
  end

  // Table entry fetch: low byte at the even address, high byte after it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      table_state <= AGU_TB_IDLE;
      table_read  <= 1'b0;
      table_addr  <= AGU_TABLE_BASE;
      table_low   <= 8'h00;
      branch_busy <= 1'b0;
    end else begin
      case (table_state)
        AGU_TB_IDLE: begin
          table_read  <= 1'b0;
          branch_busy <= 1'b0;
          if (branch_valid && branch_kind == AGU_BR_TABLE) begin
            table_state <= AGU_TB_LOW;
            table_read  <= 1'b1;
            table_addr  <= next_table_addr;
            branch_busy <= 1'b1;
          end
        end
        AGU_TB_LOW: begin
          table_low   <= table_data;
          table_state <= AGU_TB_HIGH;
          table_addr  <= table_addr | 16'h0001;
        end
        AGU_TB_HIGH: begin
          table_state <= AGU_TB_IDLE;
          table_read  <= 1'b0;
          branch_busy <= 1'b0;
        end
        default: begin
          table_state <= AGU_TB_IDLE;
          table_read  <= 1'b0;
          branch_busy <= 1'b0;
        end
      endcase
    end
  end

  // Registered operand address
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      operand_addr_valid <= 1'b0;
      operand_addr       <= 16'h0000;
      operand_in_ram     <= 1'b0;
      operand_in_sfr     <= 1'b0;
      operand_unmapped   <= 1'b0;
    end else begin
      operand_addr_valid <= operand_valid && (operand_mode != AGU_OP_NONE);
      operand_addr       <= next_operand_addr;
      operand_in_ram     <= next_in_ram;
      operand_in_sfr     <= next_in_sfr;
      operand_unmapped   <= next_unmapped;
    end
  end

  // Register file indices: bank above code, pair index joins the bank with the 2-bit pair code
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      byte_register_index <= 5'h00;
      pair_register_index <= 4'h0;
    end else begin
      byte_register_index <= {bank, byte_register_code};
      pair_register_index <= {bank, pair_register_code};
    end
  end

  // Implied accumulator addressing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      implied_valid        <= 1'b0;
      implied_source_index <= 5'h00;
      implied_dest_pair    <= 4'h0;
    end else begin
      implied_valid     <= operand_valid && (implied_op != AGU_IMP_NONE);
      implied_dest_pair <= {bank, AGU_PAIR_AX};
      case (implied_op)
        AGU_IMP_MUL: implied_source_index <= {bank, AGU_REG_A};
        AGU_IMP_DIV: implied_source_index <= {bank, AGU_REG_X};
        AGU_IMP_ADJ: implied_source_index <= {bank, AGU_REG_A};
        AGU_IMP_ROT: implied_source_index <= {bank, AGU_REG_A};
        default:     implied_source_index <= {bank, AGU_REG_A};
      endcase
    end
  end

  // Memory size register; software is expected to overwrite the reset value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memory_size_register <= AGU_MEMSIZE_RESET;
    end else if (memsize_write) begin
      memory_size_register <= memsize_data;
    end
  end

  // Strap followed until the synchroniser has settled, then frozen;
  // async reset may only load constants, so the first edges show user mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flash_mode_register <= AGU_FLASH_USER;
      strap_count         <= 3'h0;
    end else if (strap_count != 3'(AGU_STRAP_SETTLE)) begin
      strap_count         <= strap_count + 3'h1;
      flash_mode_register <= onboard_level ? AGU_FLASH_ONBOARD : AGU_FLASH_USER;
    end
  end

endmodule
`default_nettype wire

// ==== verif/agu_chk_sva.sv ====
// Checker for the address generation unit, watching only its ports.
// Assumes it is bound to agu_top; all requests are taken on rising mclk.
`timescale 1ns/1ps
`default_nettype none
module agu_chk
  import agu_pkg::*;
(
  // Clock and reset
  input wire logic         mclk,
  input wire logic         rst_n,
  // Requests
  input wire logic         step_valid,
  input wire logic [1:0]   step_length,
  input wire logic         branch_valid,
  input wire agu_branch_e  branch_kind,
  input wire logic [7:0]   relative_displacement,
  input wire logic [15:0]  branch_immediate,
  input wire logic [10:0]  fast_call_target_field,
  input wire logic [7:0]   table_opcode,
  input wire logic         operand_valid,
  input wire agu_opmode_e  operand_mode,
  input wire logic [15:0]  operand_immediate,
  input wire logic [15:0]  accumulator_pair,
  // Answers
  input wire logic [15:0]  program_counter,
  input wire logic         branch_busy,
  input wire logic         table_read,
  input wire logic [15:0]  table_addr,
  input wire logic         operand_addr_valid,
  input wire logic [15:0]  operand_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic        go;
  logic [15:0] rel_sum;
  logic [15:0] short_addr;
  logic [15:0] tbl_addr;
  // A busy table fetch swallows branch requests
  assign go = branch_valid && !branch_busy;
  assign rel_sum = program_counter + {{8{relative_displacement[7]}}, relative_displacement};
  assign short_addr = {7'h7F, operand_immediate[7:0] < 8'h20, operand_immediate[7:0]};
  assign tbl_addr = {9'h000, 1'b1, table_opcode[5:1], 1'b0};

  a_step_advance: assert property (
    step_valid && !go && !branch_busy
    |=> program_counter == $past(program_counter) + 16'($past(step_length)))
    else $error("step did not advance the counter by its length");
  a_rel_target: assert property (
    go && branch_kind == AGU_BR_REL |=> program_counter == $past(rel_sum))
    else $error("relative target wrong");
  a_imm_target: assert property (
    go && branch_kind == AGU_BR_IMM16 |=> program_counter == $past(branch_immediate))
    else $error("immediate target wrong");
  a_fast_target: assert property (
    go && branch_kind == AGU_BR_FAST
    |=> program_counter == {5'h01, $past(fast_call_target_field)})
    else $error("fast call target wrong");
  a_table_fetch: assert property (
    go && branch_kind == AGU_BR_TABLE
    |=> table_read && branch_busy && table_addr == $past(tbl_addr)
    ##1 table_read && table_addr == $past(table_addr) + 16'h0001)
    else $error("table fetch address wrong");
  a_pair_target: assert property (
    go && branch_kind == AGU_BR_PAIR |=> program_counter == $past(accumulator_pair))
    else $error("pair target wrong");
  a_short_addr: assert property (
    operand_valid && operand_mode == AGU_OP_SHORT
    |=> operand_addr_valid && operand_addr == $past(short_addr))
    else $error("short direct address wrong");
  a_specl_addr: assert property (
    operand_valid && operand_mode == AGU_OP_SPECL
    |=> operand_addr_valid && operand_addr[15:8] == 8'hFF
    && operand_addr[7:0] == $past(operand_immediate[7:0]))
    else $error("special register address wrong");
  a_direct_addr: assert property (
    operand_valid && operand_mode == AGU_OP_DIRECT
    |=> operand_addr == $past(operand_immediate))
    else $error("direct address wrong");
  c_table: cover property (go && branch_kind == AGU_BR_TABLE);
  c_short: cover property (operand_valid && operand_mode == AGU_OP_SHORT);
  c_rel: cover property (go && branch_kind == AGU_BR_REL);
endmodule
`default_nettype wire

// ==== verif/agu_tb.sv ====
// Self-checking bench for the address generation unit.
// Assumes the strap is low until the mid-run reset scenario and stays high from then on.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import agu_pkg::*;
  logic mclk, rst_n, onboard_mode_pin, bank_select_low, bank_select_high;
  logic step_valid, branch_valid, operand_valid, memsize_write;
  logic branch_busy, table_read, operand_addr_valid, operand_in_ram;
  logic operand_in_sfr, operand_unmapped, implied_valid;
  logic [1:0] step_length, pair_register_code;
  logic [2:0] byte_register_code;
  logic [4:0] byte_register_index, implied_source_index;
  logic [3:0] pair_register_index, implied_dest_pair;
  logic [7:0] relative_displacement, table_opcode, table_data, memsize_data;
  logic [7:0] memory_size_register, flash_mode_register;
  logic [10:0] fast_call_target_field;
  logic [15:0] branch_immediate, operand_immediate, accumulator_pair, hl_pair;
  logic [15:0] program_counter, table_addr, operand_addr;
  agu_branch_e branch_kind;
  agu_opmode_e operand_mode;
  agu_implied_e implied_op;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  agu_top agu_top_inst (.*);

  task automatic test_done;
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // One data word feeds every branch field; the kind picks which is used
  task automatic branch(agu_branch_e k, logic [15:0] d, logic [15:0] pc);
    @(posedge mclk);
    branch_kind <= k;
    branch_immediate <= d;
    relative_displacement <= d[7:0];
    fast_call_target_field <= d[10:0];
    table_opcode <= d[7:0];
    accumulator_pair <= d;
    branch_valid <= 1'b1;
    @(posedge mclk);
    branch_valid <= 1'b0;
    #1;
    if (k != AGU_BR_TABLE)
      chk("pc", program_counter, pc);
  endtask

  // Flags are {ram, sfr, unmapped}, judged only for the windowed modes
  task automatic op(agu_opmode_e m, logic [15:0] imm, logic [15:0] ea, logic [2:0] fl);
    @(posedge mclk);
    operand_mode <= m;
    operand_immediate <= imm;
    operand_valid <= 1'b1;
    @(posedge mclk);
    operand_valid <= 1'b0;
    #1 chk("op addr", operand_addr, ea);
    chk("op valid", operand_addr_valid, 1'b1);
    if (m inside {AGU_OP_SHORT, AGU_OP_SPECL})
      chk("op flags", {operand_in_ram, operand_in_sfr, operand_unmapped}, fl);
  endtask

  task automatic t_step;
    logic [15:0] pc;
    pc = program_counter;
    @(posedge mclk);
    step_valid <= 1'b1;
    step_length <= 2'h1;
    @(posedge mclk);
    step_length <= 2'h2;
    @(posedge mclk);
    step_length <= 2'h3;
    @(posedge mclk);
    step_valid <= 1'b0;
    #1 chk("pc step", program_counter, pc + 16'h0006);
  endtask

  // A step offered while the table words are fetched must be ignored
  task automatic t_table;
    branch(AGU_BR_TABLE, 16'h003E, 16'h0000);
    chk("tbl busy", {table_read, branch_busy}, 2'h3);
    chk("tbl lo addr", table_addr, 16'h007E);
    table_data <= 8'h34;
    step_valid <= 1'b1;
    step_length <= 2'h3;
    @(posedge mclk);
    table_data <= 8'hA2;
    step_valid <= 1'b0;
    #1 chk("tbl hi addr", table_addr, 16'h007F);
    @(posedge mclk);
    #1 chk("tbl pc", program_counter, 16'hA234);
    chk("tbl idle", {table_read, branch_busy}, 2'h0);
  endtask

  // Each bank in turn, with the implied operations alongside
  task automatic t_regs;
    for (int i = 1; i < 5; i++) begin
      {bank_select_high, bank_select_low} <= 2'(i - 1);
      byte_register_code <= 3'(2 * i - 1);
      pair_register_code <= 2'(i - 1);
      implied_op <= agu_implied_e'(i);
      op(AGU_OP_DIRECT, 16'h0100, 16'h0100, 3'h0);
      chk("byte idx", byte_register_index, {2'(i - 1), 3'(2 * i - 1)});
      chk("pair idx", pair_register_index, {2'(i - 1), 2'(i - 1)});
      chk("imp src", implied_source_index, {2'(i - 1), 2'h0, (i != 2)});
      chk("imp dst", {implied_valid, implied_dest_pair}, {1'b1, 2'(i - 1), 2'h0});
    end
  endtask

  // Mid-run reset with the strap high; the register follows it once the sync settles
  task automatic t_strap;
    @(posedge mclk);
    onboard_mode_pin <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk("flash rst2", flash_mode_register, 8'h08);
    chk("pc rst2", program_counter, 16'h0000);
    repeat (6) @(posedge mclk);
    #1 chk("flash obd", flash_mode_register, 8'h0C);
    chk("size rst2", memory_size_register, 8'hCF);
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      test_done;
    end
  end

  initial begin
    {rst_n, onboard_mode_pin, bank_select_low, bank_select_high} = 4'h0;
    {step_valid, branch_valid, operand_valid, memsize_write} = 4'h0;
    {step_length, pair_register_code, byte_register_code} = 7'h00;
    {relative_displacement, table_opcode, table_data, memsize_data} = 32'h0;
    {fast_call_target_field, branch_immediate, operand_immediate} = 43'h0;
    accumulator_pair = 16'h0000;
    hl_pair = 16'hFFF0;
    branch_kind = AGU_BR_NONE;
    operand_mode = AGU_OP_NONE;
    implied_op = AGU_IMP_NONE;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk("pc rst", program_counter, 16'h0000);
    chk("size rst", memory_size_register, 8'hCF);
    @(posedge mclk);
    #1 chk("flash rst", flash_mode_register, 8'h08);
    t_step();
    branch(AGU_BR_IMM16, 16'h0005, 16'h0005);
    branch(AGU_BR_REL, 16'h0080, 16'hFF85);
    branch(AGU_BR_REL, 16'h007F, 16'h0004);
    branch(AGU_BR_FAST, 16'h07FF, 16'h0FFF);
    branch(AGU_BR_FAST, 16'hF800, 16'h0800);
    branch(AGU_BR_PAIR, 16'hBEEF, 16'hBEEF);
    t_table();
    op(AGU_OP_SHORT, 16'h0010, 16'hFF10, 3'h2);
    op(AGU_OP_SHORT, 16'h0020, 16'hFE20, 3'h4);
    op(AGU_OP_SHORT, 16'h00FF, 16'hFEFF, 3'h4);
    op(AGU_OP_SHORT, 16'h001F, 16'hFF1F, 3'h2);
    op(AGU_OP_SPECL, 16'h0000, 16'hFF00, 3'h2);
    op(AGU_OP_SPECL, 16'h00CF, 16'hFFCF, 3'h2);
    op(AGU_OP_SPECL, 16'h00D5, 16'hFFD5, 3'h1);
    op(AGU_OP_SPECL, 16'h00E0, 16'hFFE0, 3'h2);
    op(AGU_OP_DIRECT, 16'hABCD, 16'hABCD, 3'h0);
    op(AGU_OP_BASED, 16'h0020, 16'h0010, 3'h0);
    t_regs();
    t_strap();
    @(posedge mclk);
    memsize_data <= 8'h42;
    memsize_write <= 1'b1;
    @(posedge mclk);
    memsize_write <= 1'b0;
    #1 chk("size wr", memory_size_register, 8'h42);
    test_done;
  end
endmodule
bind agu_top agu_chk agu_chk_inst (.*);
`default_nettype wire
